// ===== verilog/rct_pkg.sv
// Shared constants of the remote carrier timer
package rct_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CNT_W = 9;
   // Register byte addresses
   localparam logic [7:0] TIMER_COUNT_LOW_ADDR = 8'h18;
   localparam logic [7:0] TIMER_CONTROL_HIGH_ADDR = 8'h19;
   localparam logic [7:0] CARRIER_LOW_PERIOD_LO_ADDR = 8'h1A;
   localparam logic [7:0] CARRIER_LOW_PERIOD_HI_ADDR = 8'h1B;
   localparam logic [7:0] CARRIER_HIGH_PERIOD_LO_ADDR = 8'h1C;
   localparam logic [7:0] CARRIER_HIGH_PERIOD_HI_ADDR = 8'h1D;
   // Field positions
   localparam int COUNT_MSB_BIT = 0;
   localparam int OUTPUT_ENABLE_BIT = 1;
   localparam int TIMER_END_BIT = 7;
   localparam int MOD_MSB_BIT = 0;
   localparam int CARRIER_DISABLE_BIT = 1;
   // Reset values
   localparam logic [7:0] TIMER_COUNT_LOW_RST = 8'h00;
   localparam logic [7:0] TIMER_CONTROL_HIGH_RST = 8'h80;
   localparam logic [7:0] CARRIER_LOW_LO_RST = 8'h00;
   localparam logic [7:0] CARRIER_LOW_HI_RST = 8'h00;
   localparam logic [7:0] CARRIER_HIGH_LO_RST = 8'h00;
   localparam logic [7:0] CARRIER_HIGH_HI_RST = 8'h02;
   // Timer step in system clocks
   localparam int TICK_CYCLES = 64;
   localparam int TICK_W = 6;
endpackage : rct_pkg

// ===== verilog/rct_car_if.sv
// Link between the timer core and the carrier generator
`timescale 1ns/1ps
interface rct_car_if;
   logic gate;
   logic [8:0] low_mod;
   logic [8:0] high_mod;
   logic level;
   logic busy;
   modport core (output gate, output low_mod, output high_mod, input level, input busy);
   modport gen (input gate, input low_mod, input high_mod, output level, output busy);
endinterface : rct_car_if

// ===== verilog/rct_prescaler.sv
// Divider producing one tick every timer step
`timescale 1ns/1ps
module rct_prescaler #(
   parameter int STEP = rct_pkg::TICK_CYCLES
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic run_in,
   output logic tick_out
);
   localparam logic [rct_pkg::TICK_W-1:0] LAST = rct_pkg::TICK_W'(STEP - 1);
   logic [rct_pkg::TICK_W-1:0] div_reg;

   // Held at zero while idle so every run started from idle gets full-length steps
   always_ff @(posedge clk_in) begin
      if (srst_in || !run_in) begin
         div_reg <= '0;
      end else if (div_reg == LAST) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   assign tick_out = run_in && (div_reg == LAST);
endmodule : rct_prescaler

// ===== verilog/rct_carrier.sv
// Carrier waveform generator with separate low and high periods
`timescale 1ns/1ps
module rct_carrier (
   input wire logic clk_in,
   input wire logic srst_in,
   rct_car_if.gen car
);
   logic [8:0] cnt_reg;
   logic high_reg;
   logic busy_reg;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cnt_reg <= '0;
         high_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else if (!busy_reg) begin
         if (car.gate) begin
            busy_reg <= 1'b1;
            high_reg <= 1'b0;
            cnt_reg <= car.low_mod;
         end
      end else if (cnt_reg == 9'h000) begin
         if (high_reg) begin
            // A fallen gate still lets the high phase end first
            high_reg <= 1'b0;
            cnt_reg <= car.low_mod;
            busy_reg <= car.gate;
         end else if (car.gate) begin
            high_reg <= 1'b1;
            cnt_reg <= car.high_mod;
         end else begin
            busy_reg <= 1'b0;
         end
      end else if (!car.gate && !high_reg) begin
         busy_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg - 9'h001;
      end
   end

   assign car.level = high_reg;
   assign car.busy = busy_reg;
endmodule : rct_carrier

// ===== verilog/rct_top.sv
// Remote carrier timer: register file, down timer and output pin
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Nine-bit down counter, enable flag, zero detect
// - Low write stores; high write loads counter
// - Load clears end flag, waits for enable
// - Enable starts count; zero stops, sets end
// - Clearing enable halts; re-enable reloads, restarts
// - Both flags set: new data restarts timer
// - Counter steps once per 64 clocks
// - Output lasts value plus one steps
// - End signal holds while stopped at zero
// - Carrier: one counter, two period values
// - Each phase lasts value plus one clocks
// - Widths programmable across nine-bit range
// - Disable resets one; unused bits read zero
// - Clearing disable puts carrier on pin
// - Pin follows disable, enable and counter
// - Disabled carrier: pin mirrors enable flag
// - Carrier starts with its low phase
// - Falling timer finishes current high phase
module rct_top #(
   parameter int STEP = rct_pkg::TICK_CYCLES
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [rct_pkg::ADDR_W-1:0] addr_in,
   input wire logic [rct_pkg::DATA_W-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [rct_pkg::DATA_W-1:0] rdata_out,
   output logic remote_output_pin_out,
   output logic timer_end_out
);
   // Stored values written by software
   logic [7:0] count_low_reg;
   logic count_msb_reg;
   logic output_enable_flag_reg;
   logic timer_end_flag_reg;
   logic [8:0] low_period_modulo_reg;
   logic [8:0] high_period_modulo_reg;
   logic carrier_disable_bit_reg;
   // Timer state
   logic [rct_pkg::CNT_W-1:0] down_cnt_reg;
   logic running_reg;
   logic tick;
   logic end_detect;
   logic remote_reg;
   logic remote_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic wr_ctrl;

   // Upper modulo bits at reset, taken from the high-byte reset values
   localparam logic CARRIER_LOW_HI_RST_B = rct_pkg::CARRIER_LOW_HI_RST[rct_pkg::MOD_MSB_BIT];
   localparam logic CARRIER_HIGH_HI_RST_B = rct_pkg::CARRIER_HIGH_HI_RST[rct_pkg::MOD_MSB_BIT];

   rct_car_if car ();

   function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
      hit = (a == base);
   endfunction : hit

   assign wr_ctrl = wr_in && hit(addr_in, rct_pkg::TIMER_CONTROL_HIGH_ADDR);

   rct_prescaler #(.STEP(STEP)) u_pre (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .run_in(running_reg),
      .tick_out(tick)
   );

   rct_carrier u_car (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .car(car)
   );

   // Software-written carrier settings
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         low_period_modulo_reg <= {CARRIER_LOW_HI_RST_B, rct_pkg::CARRIER_LOW_LO_RST};
         high_period_modulo_reg <= {CARRIER_HIGH_HI_RST_B, rct_pkg::CARRIER_HIGH_LO_RST};
         carrier_disable_bit_reg <= rct_pkg::CARRIER_HIGH_HI_RST[rct_pkg::CARRIER_DISABLE_BIT];
      end else if (wr_in) begin
         if (hit(addr_in, rct_pkg::CARRIER_LOW_PERIOD_LO_ADDR)) begin
            low_period_modulo_reg[7:0] <= wdata_in;
         end
         if (hit(addr_in, rct_pkg::CARRIER_LOW_PERIOD_HI_ADDR)) begin
            low_period_modulo_reg[8] <= wdata_in[rct_pkg::MOD_MSB_BIT];
         end
         if (hit(addr_in, rct_pkg::CARRIER_HIGH_PERIOD_LO_ADDR)) begin
            high_period_modulo_reg[7:0] <= wdata_in;
         end
         if (hit(addr_in, rct_pkg::CARRIER_HIGH_PERIOD_HI_ADDR)) begin
            high_period_modulo_reg[8] <= wdata_in[rct_pkg::MOD_MSB_BIT];
            carrier_disable_bit_reg <= wdata_in[rct_pkg::CARRIER_DISABLE_BIT];
         end
      end
   end

   // Low count byte is only stored; the counter is not touched
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         count_low_reg <= rct_pkg::TIMER_COUNT_LOW_RST;
      end else if (wr_in && hit(addr_in, rct_pkg::TIMER_COUNT_LOW_ADDR)) begin
         count_low_reg <= wdata_in;
      end
   end

   // Down timer. A control write always reloads from the stored value,
   // so a bit-set of the enable flag also restarts from the full count.
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         count_msb_reg <= rct_pkg::TIMER_CONTROL_HIGH_RST[rct_pkg::COUNT_MSB_BIT];
         output_enable_flag_reg <= rct_pkg::TIMER_CONTROL_HIGH_RST[rct_pkg::OUTPUT_ENABLE_BIT];
         down_cnt_reg <= '0;
         running_reg <= 1'b0;
      end else if (wr_ctrl) begin
         count_msb_reg <= wdata_in[rct_pkg::COUNT_MSB_BIT];
         down_cnt_reg <= {wdata_in[rct_pkg::COUNT_MSB_BIT], count_low_reg};
         output_enable_flag_reg <= wdata_in[rct_pkg::OUTPUT_ENABLE_BIT];
         running_reg <= wdata_in[rct_pkg::OUTPUT_ENABLE_BIT];
      end else if (tick) begin
         if (down_cnt_reg == '0) begin
            running_reg <= 1'b0;
         end else begin
            down_cnt_reg <= down_cnt_reg - 9'h001;
         end
      end
   end

   assign end_detect = (down_cnt_reg == '0) && !running_reg;

   // End flag: an expiring count beats a clearing write in the same cycle
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         timer_end_flag_reg <= rct_pkg::TIMER_CONTROL_HIGH_RST[rct_pkg::TIMER_END_BIT];
      end else if (tick && running_reg && down_cnt_reg == '0) begin
         timer_end_flag_reg <= 1'b1;
      end else if (wr_ctrl) begin
         timer_end_flag_reg <= 1'b0;
      end
   end

   // Carrier gate: open only while the timer is counting and carrier is enabled
   assign car.gate = running_reg && !carrier_disable_bit_reg;
   assign car.low_mod = low_period_modulo_reg;
   assign car.high_mod = high_period_modulo_reg;

   always_comb begin
      if (carrier_disable_bit_reg) begin
         remote_next = output_enable_flag_reg;
      end else begin
         remote_next = car.busy && car.level;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         remote_reg <= 1'b0;
      end else begin
         remote_reg <= remote_next;
      end
   end

   // Read mux; unused and unmapped bits read as zero
   always_comb begin
      rdata_next = 8'h00;
      case (addr_in)
         rct_pkg::TIMER_COUNT_LOW_ADDR: begin
            rdata_next = count_low_reg;
         end
         rct_pkg::TIMER_CONTROL_HIGH_ADDR: begin
            rdata_next[rct_pkg::COUNT_MSB_BIT] = count_msb_reg;
            rdata_next[rct_pkg::OUTPUT_ENABLE_BIT] = output_enable_flag_reg;
            rdata_next[rct_pkg::TIMER_END_BIT] = timer_end_flag_reg;
         end
         rct_pkg::CARRIER_LOW_PERIOD_LO_ADDR: begin
            rdata_next = low_period_modulo_reg[7:0];
         end
         rct_pkg::CARRIER_LOW_PERIOD_HI_ADDR: begin
            rdata_next[rct_pkg::MOD_MSB_BIT] = low_period_modulo_reg[8];
         end
         rct_pkg::CARRIER_HIGH_PERIOD_LO_ADDR: begin
            rdata_next = high_period_modulo_reg[7:0];
         end
         rct_pkg::CARRIER_HIGH_PERIOD_HI_ADDR: begin
            rdata_next[rct_pkg::MOD_MSB_BIT] = high_period_modulo_reg[8];
            rdata_next[rct_pkg::CARRIER_DISABLE_BIT] = carrier_disable_bit_reg;
         end
         default: begin
            rdata_next = 8'h00;
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rdata_reg <= 8'h00;
      end else if (rd_in) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         timer_end_out <= rct_pkg::TIMER_CONTROL_HIGH_RST[rct_pkg::TIMER_END_BIT];
      end else begin
         timer_end_out <= end_detect;
      end
   end

   assign rdata_out = rdata_reg;
   assign remote_output_pin_out = remote_reg;
endmodule : rct_top

// ===== tb/rct_top_properties.sv
// Port-level checks of the remote carrier timer
`timescale 1ns/1ps
module rct_top_properties #(
   parameter int STEP = rct_pkg::TICK_CYCLES
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic remote_output_pin_out,
   input wire logic timer_end_out
);
   logic dis_reg;
   logic en_reg;
   logic [9:0] off_reg;
   logic ctl_wr;
   assign ctl_wr = wr_in && addr_in == 8'h19;
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // Shadows of the two control bits, rebuilt from bus writes
   always_ff @(posedge clk_in) begin
      if (srst_in) dis_reg <= 1'b1;
      else if (wr_in && addr_in == 8'h1D) dis_reg <= wdata_in[1];
   end
   always_ff @(posedge clk_in) begin
      if (srst_in) en_reg <= 1'b0;
      else if (ctl_wr) en_reg <= wdata_in[1];
   end
   always_ff @(posedge clk_in) begin
      if (srst_in || dis_reg || en_reg) off_reg <= 10'h000;
      else if (off_reg != 10'h3FF) off_reg <= off_reg + 10'h001;
   end
   property p_rd_idle; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
   property p_unmapped; rd_in && (addr_in < 8'h18 || addr_in > 8'h1D) |=> rdata_out == 8'h00;
   endproperty
   property p_ctl_unused; rd_in && addr_in == 8'h19 |=> rdata_out[6:2] == 5'h00; endproperty
   property p_low_fix; rd_in && addr_in == 8'h1B |=> rdata_out[7:1] == 7'h00; endproperty
   property p_load_clear; ctl_wr && wdata_in[0] |-> ##2 !timer_end_out; endproperty
   property p_end_hold; timer_end_out && !ctl_wr && !$past(ctl_wr) |=> timer_end_out;
   endproperty
   property p_mirror; dis_reg && $past(dis_reg) |-> remote_output_pin_out == $past(en_reg);
   endproperty
   property p_low_first;
      !dis_reg && !en_reg && ctl_wr && wdata_in[1] && !remote_output_pin_out
         |=> !remote_output_pin_out [*3];
   endproperty
   // High phase may finish first, so allow well over 512 clocks
   property p_off_low; off_reg > 10'd600 |-> !remote_output_pin_out; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_ctl_unused: assert property (p_ctl_unused) else $error("unused bits set");
   a_low_fix: assert property (p_low_fix) else $error("low period bit9 set");
   a_load_clear: assert property (p_load_clear) else $error("end not cleared");
   a_end_hold: assert property (p_end_hold) else $error("end signal dropped");
   a_mirror: assert property (p_mirror) else $error("pin not mirroring enable");
   a_low_first: assert property (p_low_first) else $error("carrier not low first");
   a_off_low: assert property (p_off_low) else $error("pin high while disabled");
   c_start: cover property (ctl_wr && wdata_in[1]);
   c_end: cover property ($rose(timer_end_out));
   c_carrier: cover property (!dis_reg && remote_output_pin_out);
endmodule : rct_top_properties

bind rct_top rct_top_properties #(.STEP(STEP)) rct_top_properties_i (.clk_in(clk_in),
   .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .remote_output_pin_out(remote_output_pin_out),
   .timer_end_out(timer_end_out));

// ===== tb/rct_emitter_model.sv
// Emitter stage model: records the last complete high and low widths
`timescale 1ns/1ps
module rct_emitter_model (
   input wire logic clk_in,
   input wire logic drive_in,
   output logic [15:0] high_len_out,
   output logic [15:0] low_len_out
);
   logic [15:0] run_reg = 16'h0000;
   logic last_reg = 1'b0;
   initial high_len_out = 16'h0000;
   initial low_len_out = 16'h0000;
   always @(posedge clk_in) begin
      if (drive_in !== last_reg) begin
         if (last_reg) high_len_out <= run_reg;
         else low_len_out <= run_reg;
         run_reg <= 16'h0001;
      end else run_reg <= run_reg + 16'h0001;
      last_reg <= drive_in;
   end
endmodule : rct_emitter_model

// ===== tb/tb_rct_top.sv
// Self-checking bench of the remote carrier timer
`timescale 1ns/1ps
module tb_rct_top;
   localparam int STEP = 4;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic remote_output_pin_out;
   logic timer_end_out;
   logic [15:0] high_len;
   logic [15:0] low_len;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   always #50 clk_in = ~clk_in;
   rct_top #(.STEP(STEP)) rct_top_i (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .remote_output_pin_out(remote_output_pin_out), .timer_end_out(timer_end_out));
   rct_emitter_model rct_emitter_model_i (.clk_in(clk_in), .drive_in(remote_output_pin_out),
      .high_len_out(high_len), .low_len_out(low_len));
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         fails++;
         close_out();
      end
   end
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : check_val
   // Timer durations carry a small slack for pipeline stages the rules leave open; carrier widths are checked exactly
   task automatic check_len(input logic [15:0] got, input int exp, input int tol);
      comparisons++;
      if (int'(got) < exp - tol || int'(got) > exp + tol) begin
         fails++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : check_len
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      check_val(rdata_out, exp);
   endtask : rd
   task automatic wait_end(output int n);
      repeat (2) @(negedge clk_in);
      n = 2;
      while (timer_end_out !== 1'b1 && n < 5000) begin
         @(negedge clk_in);
         n++;
      end
   endtask : wait_end
   function automatic int exp_ticks(input logic [8:0] n);
      return (int'(n) + 1) * STEP + 1;
   endfunction : exp_ticks
   task automatic run_timer(input logic [8:0] n);
      int t;
      wr(8'h18, n[7:0]);
      wr(8'h19, {6'h00, 1'b1, n[8]});
      wait_end(t);
      check_len(16'(t), exp_ticks(n), 2);
      rd(8'h19, {1'b1, 5'h00, 1'b1, n[8]});
   endtask : run_timer
   logic [7:0] rst_v [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h02};
   logic [7:0] msk [4] = '{8'hFF, 8'h01, 8'hFF, 8'h03};
   logic [8:0] lo;
   logic [8:0] hi;
   logic [7:0] d;
   int t;
   initial begin
      void'($urandom(91965));
      repeat (4) @(posedge clk_in);
      srst_in <= 1'b0;
      for (int i = 0; i < 6; i++) rd(8'h18 + 8'(i), rst_v[i]);
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         wr(8'h1A + 8'(i), d);
         rd(8'h1A + 8'(i), d & msk[i]);
      end
      wr(8'h1D, 8'h02);
      run_timer(9'h000);
      run_timer(9'h001);
      run_timer(9'h100 | 9'($urandom % 256));
      wr(8'h18, 8'h05);
      wr(8'h19, 8'h03);
      repeat (40) @(posedge clk_in);
      wr(8'h19, 8'h01);
      repeat (100) @(negedge clk_in);
      check_val({7'h00, timer_end_out}, 8'h00);
      rd(8'h19, 8'h01);
      wr(8'h19, 8'h03);
      wait_end(t);
      check_len(16'(t), exp_ticks(9'h105), 2);
      // Pin must be low before the periods change
      wr(8'h19, 8'h00);
      for (int k = 0; k < 2; k++) begin
         lo = (k == 0) ? 9'h001 : 9'(1 + $urandom % 40);
         hi = (k == 0) ? 9'h001 : 9'(1 + $urandom % 40);
         wr(8'h1A, lo[7:0]);
         wr(8'h1B, {7'h00, lo[8]});
         wr(8'h1C, hi[7:0]);
         wr(8'h1D, {6'h00, 1'b0, hi[8]});
         run_timer(9'h0C8);
         repeat (100) @(negedge clk_in);
         check_len(high_len, int'(hi) + 1, 0);
         check_len(low_len, int'(lo) + 1, 0);
         check_val({7'h00, remote_output_pin_out}, 8'h00);
         wr(8'h19, 8'h00);
         repeat (620) @(negedge clk_in);
         wr(8'h1D, 8'h02);
      end
      // Reset in mid-run: registers and pin return to their reset state
      wr(8'h18, 8'h40);
      wr(8'h19, 8'h03);
      repeat (10) @(negedge clk_in);
      check_val({7'h00, remote_output_pin_out}, 8'h01);
      @(posedge clk_in);
      srst_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      srst_in <= 1'b0;
      for (int i = 0; i < 6; i++) rd(8'h18 + 8'(i), rst_v[i]);
      check_val({7'h00, remote_output_pin_out}, 8'h00);
      check_val({7'h00, timer_end_out}, 8'h01);
      close_out();
   end
endmodule : tb_rct_top
